/* verilog/fsp_top.sv */
// Operation
// - Buffer-clear bit set by software, hardware clears
// - Buffer-clear register bits 7..1 read zero
// - Low address register, read/write, resets zero
// - High address width follows memory size
// - Four 16-bit data words, byte registers
// - Unlock start runs a 300 us timeout
// - Timeout or bad pattern aborts, clears unlock
// - Good pattern sets write-enabled, clears unlock
// - Flash changes refused unless write-enabled
// - Clearing write-enabled flag blocks writes again
// - Small sizes erase 256-word blocks, high only
// - Block from high bits 2..0 or 3..0
// - Large sizes erase 32 or 64-word pages
// - Page number is high and upper low bits
// - Processor stalls while write or read pending
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.svh"
module fsp_top #(
  parameter int MEM_SIZE = 3,
  parameter int SLOW_HZ = `FSP_SLOW_OSC_HZ
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // AHB-Lite slave
  input wire logic hsel_i,
  input wire logic [31:0] haddr_i,
  input wire logic [1:0] htrans_i,
  input wire logic hwrite_i,
  input wire logic [2:0] hsize_i,
  input wire logic [31:0] hwdata_i,
  input wire logic hready_i,
  output logic [31:0] hrdata_o,
  output logic hreadyout_o,
  output logic hresp_o,
  // Flash array
  output logic flash_req_o,
  output fsp_pkg::fsp_cmd_t flash_cmd_o,
  output logic [13:0] flash_addr_o,
  output logic [7:0] flash_erase_unit_o,
  output logic [63:0] flash_wdata_o,
  input wire logic [15:0] flash_rdata_i,
  input wire logic flash_done_i,
  // Slow oscillator and system
  input wire logic slow_osc_i,
  output logic cpu_stall_o,
  output logic write_enabled_o
);
  import fsp_pkg::*;
  logic ap_valid_q;
  logic ap_write_q;
  logic [7:0] ap_addr_q;
  logic wr_en;
  logic wr_ctrl;
  logic wr_data;
  logic [7:0] wbyte;
  logic wen_q;
  logic [2:0] mode_q;
  logic unlock_q;
  logic wgo_q;
  logic rden_q;
  logic rgo_q;
  logic bclr_q;
  logic [7:0] addr_lo_q;
  logic [5:0] addr_hi_q;
  logic [7:0] data_q [8];
  fsp_state_t state_q;
  fsp_cmd_t cmd_q;
  logic unl_start;
  logic unl_active;
  logic unl_pass;
  logic unl_fail;
  logic unl_timeout;
  logic wgo_clr;
  logic rgo_clr;
  logic bclr_clr;
  logic rd_load;
  function automatic logic [5:0] hi_mask(input int sz);
    case (sz)
      0: hi_mask = 6'h07;
      1: hi_mask = 6'h0f;
      2: hi_mask = 6'h1f;
      default: hi_mask = 6'h3f;
    endcase
  endfunction : hi_mask
  function automatic logic [7:0] erase_unit(input int sz, input logic [5:0] hi,
                                            input logic [7:0] lo);
    case (sz)
      0: erase_unit = {5'h00, hi[2:0]};
      1: erase_unit = {4'h0, hi[3:0]};
      2: erase_unit = {hi[4:0], lo[7:5]};
      default: erase_unit = {hi[5:0], lo[7:6]};
    endcase
  endfunction : erase_unit
  // ****************************************
  // Bus address phase
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      ap_valid_q <= 1'b0;
      ap_write_q <= 1'b0;
      ap_addr_q <= 8'h00;
    end
    else if (hready_i)
    begin
      ap_valid_q <= hsel_i & htrans_i[1];
      ap_write_q <= hwrite_i;
      ap_addr_q <= haddr_i[7:0];
    end
  end
  assign hreadyout_o = 1'b1;
  assign hresp_o = 1'b0;
  assign wr_en = ap_valid_q & ap_write_q;
  assign wbyte = hwdata_i[7:0];
  assign wr_ctrl = wr_en && ap_addr_q == `FSP_OFF_CTRL;
  assign wr_data = wr_en && ap_addr_q[7:5] == `FSP_OFF_DATA_BASE && ap_addr_q[1:0] == 2'h0;
  assign unl_start = wr_ctrl && wbyte[`FSP_CTRL_UNLOCK_BIT]
    && wbyte[`FSP_CTRL_MODE_MSB:`FSP_CTRL_MODE_LSB] == `FSP_MODE_UNLOCK;
  // ****************************************
  // Read mux
  // ****************************************
  always_comb
  begin
    hrdata_o = 32'h0000_0000;
    if (ap_addr_q == `FSP_OFF_CTRL)
      hrdata_o[7:0] = {wen_q, mode_q, unlock_q, wgo_q, rden_q, rgo_q};
    else if (ap_addr_q == `FSP_OFF_BCLR)
      hrdata_o[7:0] = {7'h00, bclr_q};
    else if (ap_addr_q == `FSP_OFF_ADDR_LO)
      hrdata_o[7:0] = addr_lo_q;
    else if (ap_addr_q == `FSP_OFF_ADDR_HI)
      hrdata_o[7:0] = {2'h0, addr_hi_q};
    else if (ap_addr_q[7:5] == `FSP_OFF_DATA_BASE && ap_addr_q[1:0] == 2'h0)
      hrdata_o[7:0] = data_q[ap_addr_q[4:2]];
  end
  // ****************************************
  // Control register
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      wen_q <= 1'b0;
      mode_q <= `FSP_MODE_RST;
      unlock_q <= 1'b0;
      wgo_q <= 1'b0;
      rden_q <= 1'b0;
      rgo_q <= 1'b0;
    end
    else
    begin
      if (unl_pass)
        wen_q <= 1'b1;
      else if (wr_ctrl && !wbyte[`FSP_CTRL_WEN_BIT])
        wen_q <= 1'b0;
      if ((unl_pass || unl_fail) && !unl_start)
        unlock_q <= 1'b0;
      else if (wr_ctrl)
        unlock_q <= wbyte[`FSP_CTRL_UNLOCK_BIT];
      if (wr_ctrl)
      begin
        mode_q <= wbyte[`FSP_CTRL_MODE_MSB:`FSP_CTRL_MODE_LSB];
        rden_q <= wbyte[`FSP_CTRL_RDEN_BIT];
      end
      if (wr_ctrl && wbyte[`FSP_CTRL_WGO_BIT])
        wgo_q <= 1'b1;
      else if (wgo_clr)
        wgo_q <= 1'b0;
      if (wr_ctrl && wbyte[`FSP_CTRL_RGO_BIT])
        rgo_q <= 1'b1;
      else if (rgo_clr)
        rgo_q <= 1'b0;
    end
  end
  // ****************************************
  // Buffer clear and address registers
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
      bclr_q <= 1'b0;
    else if (wr_en && ap_addr_q == `FSP_OFF_BCLR && wbyte[`FSP_BCLR_BIT])
      bclr_q <= 1'b1;
    else if (bclr_clr)
      bclr_q <= 1'b0;
  end
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      addr_lo_q <= `FSP_REG_RST;
      addr_hi_q <= 6'h00;
    end
    else
    begin
      if (wr_en && ap_addr_q == `FSP_OFF_ADDR_LO)
        addr_lo_q <= wbyte;
      if (wr_en && ap_addr_q == `FSP_OFF_ADDR_HI)
        addr_hi_q <= wbyte[5:0] & hi_mask(MEM_SIZE);
    end
  end
  // ****************************************
  // Data word registers
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      for (int i = 0; i < 8; i++)
        data_q[i] <= `FSP_REG_RST;
    end
    else if (rd_load)
    begin
      data_q[0] <= flash_rdata_i[7:0];
      data_q[1] <= flash_rdata_i[15:8];
    end
    else if (wr_data)
      data_q[ap_addr_q[4:2]] <= wbyte;
  end
  // ****************************************
  // Unlock sequence
  // ****************************************
  fsp_timeout #(
    .SLOW_HZ(SLOW_HZ)
  ) fsp_timeout_inst (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .slow_osc_i(slow_osc_i),
    .run_i(unl_active && !unl_start),
    .expired_o(unl_timeout)
  );
  fsp_unlock fsp_unlock_inst (
    .mclk_i(mclk_i),
    .rst_b_i(rst_b_i),
    .start_i(unl_start),
    .data_wr_i(wr_data),
    .data_idx_i(ap_addr_q[4:2]),
    .data_byte_i(wbyte),
    .timeout_i(unl_timeout),
    .active_o(unl_active),
    .pass_o(unl_pass),
    .fail_o(unl_fail)
  );
  // ****************************************
  // Flash operation sequencer
  // ****************************************
  always_comb
  begin
    wgo_clr = 1'b0;
    rgo_clr = 1'b0;
    bclr_clr = 1'b0;
    rd_load = 1'b0;
    if (state_q == FSP_ST_IDLE)
    begin
      if (!bclr_q && wgo_q && !(wen_q && (mode_q == `FSP_MODE_WRITE
          || mode_q == `FSP_MODE_ERASE)))
        wgo_clr = 1'b1;
      if (!bclr_q && !wgo_q && rgo_q && !(rden_q && mode_q == `FSP_MODE_READ))
        rgo_clr = 1'b1;
    end
    else if (flash_done_i)
    begin
      case (cmd_q)
        FSP_CMD_BUFCLR: bclr_clr = 1'b1;
        FSP_CMD_READ:
        begin
          rgo_clr = 1'b1;
          rd_load = 1'b1;
        end
        FSP_CMD_ERASE: wgo_clr = 1'b1;
        FSP_CMD_WRITE: wgo_clr = 1'b1;
        default: wgo_clr = 1'b0;
      endcase
    end
  end
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      state_q <= FSP_ST_IDLE;
      cmd_q <= FSP_CMD_NONE;
    end
    else
    begin
      case (state_q)
        FSP_ST_IDLE:
        begin
          if (bclr_q)
          begin
            state_q <= FSP_ST_BUSY;
            cmd_q <= FSP_CMD_BUFCLR;
          end
          else if (wgo_q && !wgo_clr)
          begin
            state_q <= FSP_ST_BUSY;
            cmd_q <= (mode_q == `FSP_MODE_ERASE) ? FSP_CMD_ERASE : FSP_CMD_WRITE;
          end
          else if (rgo_q && !rgo_clr)
          begin
            state_q <= FSP_ST_BUSY;
            cmd_q <= FSP_CMD_READ;
          end
        end
        FSP_ST_BUSY:
        begin
          if (flash_done_i)
          begin
            state_q <= FSP_ST_IDLE;
            cmd_q <= FSP_CMD_NONE;
          end
        end
        default:
        begin
          state_q <= FSP_ST_IDLE;
          cmd_q <= FSP_CMD_NONE;
        end
      endcase
    end
  end
  assign flash_req_o = state_q == FSP_ST_BUSY;
  assign flash_cmd_o = cmd_q;
  assign flash_addr_o = {addr_hi_q, addr_lo_q};
  assign flash_erase_unit_o = erase_unit(MEM_SIZE, addr_hi_q, addr_lo_q);
  assign flash_wdata_o = {data_q[7], data_q[6], data_q[5], data_q[4],
                          data_q[3], data_q[2], data_q[1], data_q[0]};
  assign cpu_stall_o = wgo_q | rgo_q;
  assign write_enabled_o = wen_q;
  // ****************************************
  // Assertions
  // ****************************************
  property p_bclr_hi_zero;
    @(posedge mclk_i) disable iff (!rst_b_i)
    ap_valid_q && !ap_write_q && ap_addr_q == `FSP_OFF_BCLR |-> hrdata_o[31:1] == 31'h0;
  endproperty
  a_bclr_hi_zero: assert property (p_bclr_hi_zero)
    else $error("buffer clear upper bits not zero");
  property p_bclr_done;
    @(posedge mclk_i) disable iff (!rst_b_i)
    flash_req_o && cmd_q == FSP_CMD_BUFCLR && flash_done_i |=> !bclr_q && !flash_req_o;
  endproperty
  a_bclr_done: assert property (p_bclr_done)
    else $error("buffer clear bit not cleared on done");
  property p_pass;
    @(posedge mclk_i) disable iff (!rst_b_i)
    unl_pass |=> wen_q && !unlock_q;
  endproperty
  a_pass: assert property (p_pass)
    else $error("unlock pass did not enable writes");
  property p_fail;
    @(posedge mclk_i) disable iff (!rst_b_i)
    unl_fail |=> !unlock_q && wen_q == $past(wen_q);
  endproperty
  a_fail: assert property (p_fail)
    else $error("unlock fail changed write flag");
  property p_bad_byte;
    @(posedge mclk_i) disable iff (!rst_b_i)
    unl_active && !unl_timeout && wr_data && ap_addr_q[4:2] == 3'h2 && wbyte != `FSP_PAT0
      |=> unl_fail ##1 !unlock_q;
  endproperty
  a_bad_byte: assert property (p_bad_byte)
    else $error("wrong pattern byte not rejected");
  property p_refuse;
    @(posedge mclk_i) disable iff (!rst_b_i)
    (state_q == FSP_ST_IDLE && !bclr_q && wgo_q && !wen_q) |=> !flash_req_o && !wgo_q;
  endproperty
  a_refuse: assert property (p_refuse)
    else $error("write started while locked");
  property p_wen_clear;
    @(posedge mclk_i) disable iff (!rst_b_i)
    wr_ctrl && !wbyte[`FSP_CTRL_WEN_BIT] && !unl_pass |=> !wen_q;
  endproperty
  a_wen_clear: assert property (p_wen_clear)
    else $error("write flag not cleared by software");
  property p_stall;
    @(posedge mclk_i) disable iff (!rst_b_i)
    wr_ctrl && (wbyte[`FSP_CTRL_WGO_BIT] || wbyte[`FSP_CTRL_RGO_BIT]) |=> cpu_stall_o;
  endproperty
  a_stall: assert property (p_stall)
    else $error("processor not stalled");
  property p_block_lo_ignored;
    @(posedge mclk_i) disable iff (!rst_b_i)
    $changed(addr_lo_q) && $stable(addr_hi_q) && (MEM_SIZE < 2 || $stable(addr_lo_q[7:6])
      && (MEM_SIZE > 2 || $stable(addr_lo_q[5]))) |-> $stable(flash_erase_unit_o);
  endproperty
  a_block_lo_ignored: assert property (p_block_lo_ignored)
    else $error("block number depends on low address");
  property p_start;
    @(posedge mclk_i) disable iff (!rst_b_i)
    unl_start |=> unl_active && unlock_q;
  endproperty
  a_start: assert property (p_start)
    else $error("unlock did not start");
  c_pass: cover property (@(posedge mclk_i) disable iff (!rst_b_i) unl_pass);
  c_timeout: cover property (@(posedge mclk_i) disable iff (!rst_b_i) unl_timeout && unl_active);
  c_erase: cover property (@(posedge mclk_i) disable iff (!rst_b_i)
    flash_req_o && cmd_q == FSP_CMD_ERASE && flash_done_i);
  c_read: cover property (@(posedge mclk_i) disable iff (!rst_b_i) rd_load);
endmodule : fsp_top
`default_nettype wire

/* verilog/fsp_defs.svh */
`ifndef FSP_DEFS_SVH
`define FSP_DEFS_SVH
// ****************************************
// Register offsets
// ****************************************
`define FSP_OFF_CTRL 8'h00
`define FSP_OFF_BCLR 8'h04
`define FSP_OFF_ADDR_LO 8'h08
`define FSP_OFF_ADDR_HI 8'h0c
`define FSP_OFF_DATA_BASE 3'h1
// ****************************************
// Control fields
// ****************************************
`define FSP_CTRL_WEN_BIT 7
`define FSP_CTRL_MODE_MSB 6
`define FSP_CTRL_MODE_LSB 4
`define FSP_CTRL_UNLOCK_BIT 3
`define FSP_CTRL_WGO_BIT 2
`define FSP_CTRL_RDEN_BIT 1
`define FSP_CTRL_RGO_BIT 0
`define FSP_BCLR_BIT 0
`define FSP_MODE_RST 3'h7
`define FSP_REG_RST 8'h00
`define FSP_MODE_WRITE 3'h0
`define FSP_MODE_ERASE 3'h1
`define FSP_MODE_READ 3'h3
`define FSP_MODE_UNLOCK 3'h6
// ****************************************
// Unlock pattern and timing
// ****************************************
`define FSP_PAT0 8'h00
`define FSP_PAT1 8'h04
`define FSP_PAT2 8'h0d
`define FSP_PAT3 8'h09
`define FSP_PAT4 8'hc3
`define FSP_PAT5 8'h40
`define FSP_PAT_FIRST_IDX 3'h2
`define FSP_PAT_LAST_STEP 3'h5
`define FSP_TIMEOUT_US 300
`define FSP_SLOW_OSC_HZ 32000
`endif

/* verilog/fsp_pkg.sv */
package fsp_pkg;
  typedef enum logic {FSP_ST_IDLE, FSP_ST_BUSY} fsp_state_t;
  typedef enum logic [2:0] {
    FSP_CMD_NONE,
    FSP_CMD_ERASE,
    FSP_CMD_WRITE,
    FSP_CMD_READ,
    FSP_CMD_BUFCLR
  } fsp_cmd_t;
endpackage : fsp_pkg

/* verilog/fsp_timeout.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.svh"
module fsp_timeout #(
  parameter int SLOW_HZ = `FSP_SLOW_OSC_HZ
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Slow oscillator and control
  input wire logic slow_osc_i,
  input wire logic run_i,
  output logic expired_o
);
  localparam int TICKS = (`FSP_TIMEOUT_US * SLOW_HZ + 999999) / 1000000;
  localparam logic [15:0] TICKS_W = 16'(TICKS < 1 ? 1 : TICKS);
  logic sync1_q;
  logic sync2_q;
  logic sync3_q;
  logic [15:0] cnt_q;
  logic tick;
  // ****************************************
  // Slow clock synchroniser
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      sync1_q <= 1'b0;
      sync2_q <= 1'b0;
      sync3_q <= 1'b0;
    end
    else
    begin
      sync1_q <= slow_osc_i;
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end
  assign tick = sync2_q & ~sync3_q;
  // ****************************************
  // Timeout counter
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt_q <= 16'h0000;
      expired_o <= 1'b0;
    end
    else
    begin
      expired_o <= 1'b0;
      if (!run_i)
        cnt_q <= 16'h0000;
      else if (tick)
      begin
        if (cnt_q == TICKS_W - 16'h0001)
        begin
          expired_o <= 1'b1;
          cnt_q <= 16'h0000;
        end
        else
          cnt_q <= cnt_q + 16'h0001;
      end
    end
  end
endmodule : fsp_timeout
`default_nettype wire

/* verilog/fsp_unlock.sv */
`timescale 1ns/1ps
`default_nettype none
`include "fsp_defs.svh"
module fsp_unlock (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Sequence inputs
  input wire logic start_i,
  input wire logic data_wr_i,
  input wire logic [2:0] data_idx_i,
  input wire logic [7:0] data_byte_i,
  input wire logic timeout_i,
  // Sequence results
  output logic active_o,
  output logic pass_o,
  output logic fail_o
);
  logic [2:0] step_q;
  function automatic logic [7:0] pat_byte(input logic [2:0] s);
    case (s)
      3'h0: pat_byte = `FSP_PAT0;
      3'h1: pat_byte = `FSP_PAT1;
      3'h2: pat_byte = `FSP_PAT2;
      3'h3: pat_byte = `FSP_PAT3;
      3'h4: pat_byte = `FSP_PAT4;
      default: pat_byte = `FSP_PAT5;
    endcase
  endfunction : pat_byte
  // ****************************************
  // Pattern tracker
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      active_o <= 1'b0;
      step_q <= 3'h0;
      pass_o <= 1'b0;
      fail_o <= 1'b0;
    end
    else
    begin
      pass_o <= 1'b0;
      fail_o <= 1'b0;
      if (start_i)
      begin
        active_o <= 1'b1;
        step_q <= 3'h0;
      end
      else if (active_o && timeout_i)
      begin
        active_o <= 1'b0;
        fail_o <= 1'b1;
      end
      else if (active_o && data_wr_i)
      begin
        if (data_idx_i == step_q + `FSP_PAT_FIRST_IDX && data_byte_i == pat_byte(step_q))
        begin
          if (step_q == `FSP_PAT_LAST_STEP)
          begin
            active_o <= 1'b0;
            pass_o <= 1'b1;
          end
          else
            step_q <= step_q + 3'h1;
        end
        else
        begin
          active_o <= 1'b0;
          fail_o <= 1'b1;
        end
      end
    end
  end
endmodule : fsp_unlock
`default_nettype wire

/* bench/fsp_flash_model.sv */
`timescale 1ns/1ps
`default_nettype none
module fsp_flash_model #(
  parameter int DELAY = 8,
  parameter logic [15:0] RDATA = 16'h5a3c
) (
  // Clock and reset
  input wire logic mclk_i,
  input wire logic rst_b_i,
  // Request side
  input wire logic req_i,
  input wire fsp_pkg::fsp_cmd_t cmd_i,
  // Answer side
  output logic [15:0] rdata_o,
  output logic done_o,
  output logic [7:0] n_ops_o
);
  import fsp_pkg::*;
  int cnt;
  // ****************************************
  // Array timing
  // ****************************************
  always_ff @(posedge mclk_i or negedge rst_b_i)
  begin
    if (!rst_b_i)
    begin
      cnt <= 0;
      done_o <= 1'b0;
      rdata_o <= 16'h0000;
      n_ops_o <= 8'h00;
    end
    else
    begin
      done_o <= 1'b0;
      rdata_o <= (cmd_i == FSP_CMD_READ) ? ~RDATA : ~rdata_o;
      if (req_i && !done_o)
      begin
        if (cnt == DELAY)
        begin
          done_o <= 1'b1;
          rdata_o <= RDATA;
          cnt <= 0;
          n_ops_o <= n_ops_o + 8'h01;
        end
        else
          cnt <= cnt + 1;
      end
    end
  end
endmodule : fsp_flash_model
`default_nettype wire

/* bench/fsp_top_test.sv */
`timescale 1ns/1ps
`default_nettype none
module fsp_top_test;
  import fsp_pkg::*;
  logic mclk_i = 1'b0;
  logic rst_b_i = 1'b0;
  logic slow_osc_i = 1'b0;
  logic hsel_i = 1'b0;
  logic [31:0] haddr_i = 32'h0;
  logic [1:0] htrans_i = 2'h0;
  logic hwrite_i = 1'b0;
  logic [31:0] hwdata_i = 32'h0;
  logic [31:0] hrdata_o;
  logic hreadyout_o, hresp_o, flash_req_o, flash_done_i, cpu_stall_o, write_enabled_o;
  fsp_cmd_t flash_cmd_o;
  logic [13:0] flash_addr_o;
  logic [7:0] flash_erase_unit_o, n_ops;
  logic [63:0] flash_wdata_o;
  logic [15:0] flash_rdata_i;
  logic [31:0] rd;
  int mismatches = 0;
  int n_checks = 0;
  int cycles = 0;
  always #5 mclk_i = ~mclk_i;
  always #100 slow_osc_i = ~slow_osc_i;
  fsp_top #(.MEM_SIZE(3), .SLOW_HZ(100000)) fsp_top_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .hsel_i(hsel_i), .haddr_i(haddr_i),
    .htrans_i(htrans_i), .hwrite_i(hwrite_i), .hsize_i(3'h2), .hwdata_i(hwdata_i),
    .hready_i(hreadyout_o), .hrdata_o(hrdata_o), .hreadyout_o(hreadyout_o),
    .hresp_o(hresp_o), .flash_req_o(flash_req_o), .flash_cmd_o(flash_cmd_o),
    .flash_addr_o(flash_addr_o), .flash_erase_unit_o(flash_erase_unit_o),
    .flash_wdata_o(flash_wdata_o), .flash_rdata_i(flash_rdata_i),
    .flash_done_i(flash_done_i), .slow_osc_i(slow_osc_i), .cpu_stall_o(cpu_stall_o),
    .write_enabled_o(write_enabled_o));
  fsp_flash_model fsp_flash_model_inst (
    .mclk_i(mclk_i), .rst_b_i(rst_b_i), .req_i(flash_req_o), .cmd_i(flash_cmd_o),
    .rdata_o(flash_rdata_i), .done_o(flash_done_i), .n_ops_o(n_ops));
  // ****************************************
  // Shared tasks
  // ****************************************
  task summarize;
    if (mismatches == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  always @(posedge mclk_i)
  begin
    cycles <= cycles + 1;
    if (cycles == 20000)
    begin
      mismatches = mismatches + 1;
      summarize();
    end
  end
  task chk(input string nm, input logic [63:0] e, input logic [63:0] g);
    n_checks = n_checks + 1;
    if (g !== e)
    begin
      mismatches = mismatches + 1;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask : chk
  task xfer(input logic w, input logic [7:0] a, input logic [31:0] wd);
    hsel_i <= 1'b1;
    htrans_i <= 2'h2;
    haddr_i <= {24'h0, a};
    hwrite_i <= w;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    htrans_i <= 2'h0;
    hwdata_i <= wd;
    @(posedge mclk_i);
    while (hreadyout_o !== 1'b1) @(posedge mclk_i);
    rd = hrdata_o;
  endtask : xfer
  task rchk(input string nm, input logic [7:0] a, input logic [31:0] e);
    xfer(1'b0, a, 32'h0);
    chk(nm, {32'h0, e}, {32'h0, rd});
    chk("hresp", 0, hresp_o);
  endtask : rchk
  task wait_op(input fsp_cmd_t c, input logic s, input logic [7:0] u, input logic [13:0] a);
    int k;
    k = 0;
    while (flash_req_o !== 1'b1 && k < 40)
    begin
      @(posedge mclk_i);
      k++;
    end
    chk("req", 1, flash_req_o);
    chk("cmd", c, flash_cmd_o);
    chk("stall", s, cpu_stall_o);
    chk("unit", u, flash_erase_unit_o);
    chk("addr", a, flash_addr_o);
    while (flash_req_o === 1'b1 && k < 80)
    begin
      @(posedge mclk_i);
      k++;
    end
    @(posedge mclk_i);
    chk("stall end", 0, cpu_stall_o);
  endtask : wait_op
  // ****************************************
  // Scenarios
  // ****************************************
  task t_reset;
    rchk("ctrl", 8'h00, 32'h70);
    rchk("bclr", 8'h04, 32'h0);
    rchk("addr_lo", 8'h08, 32'h0);
    rchk("addr_hi", 8'h0c, 32'h0);
    for (int i = 0; i < 8; i++)
      rchk("word", 8'h20 + 8'(4 * i), 32'h0);
  endtask : t_reset
  task t_regs;
    xfer(1'b1, 8'h08, 32'ha5);
    rchk("addr_lo", 8'h08, 32'ha5);
    xfer(1'b1, 8'h0c, 32'hff);
    rchk("addr_hi", 8'h0c, 32'h3f);
    for (int i = 0; i < 8; i++)
    begin
      xfer(1'b1, 8'h20 + 8'(4 * i), {24'h0, 8'h5a ^ 8'(i)});
      rchk("word", 8'h20 + 8'(4 * i), {24'h0, 8'h5a ^ 8'(i)});
    end
    xfer(1'b1, 8'h10, 32'hff);
    rchk("unmapped", 8'h10, 32'h0);
  endtask : t_regs
  task t_bclr;
    xfer(1'b1, 8'h04, 32'hff);
    rchk("bclr busy", 8'h04, 32'h01);
    wait_op(FSP_CMD_BUFCLR, 1'b0, 8'hfe, 14'h3fa5);
    rchk("bclr done", 8'h04, 32'h0);
  endtask : t_bclr
  task t_refused;
    xfer(1'b1, 8'h00, 32'h04);
    repeat (6) @(posedge mclk_i);
    chk("ops", 1, n_ops);
    rchk("ctrl", 8'h00, 32'h00);
  endtask : t_refused
  task t_unlock(input logic [47:0] p, input logic swap, input logic [7:0] e);
    int j;
    xfer(1'b1, 8'h00, 32'h68);
    for (int i = 0; i < 6; i++)
    begin
      j = (swap && i < 2) ? 1 - i : i;
      xfer(1'b1, 8'h28 + 8'(4 * j), {24'h0, p[47 - 8 * j -: 8]});
    end
    repeat (3) @(posedge mclk_i);
    rchk("ctrl", 8'h00, {24'h0, e});
    chk("wen", e[7], write_enabled_o);
  endtask : t_unlock
  task t_timeout;
    xfer(1'b1, 8'h00, 32'h68);
    repeat (400) @(posedge mclk_i);
    rchk("ctrl run", 8'h00, 32'h68);
    repeat (400) @(posedge mclk_i);
    rchk("ctrl late", 8'h00, 32'h60);
  endtask : t_timeout
  task t_ops;
    xfer(1'b1, 8'h0c, 32'h2a);
    xfer(1'b1, 8'h08, 32'hc5);
    xfer(1'b1, 8'h00, 32'h94);
    wait_op(FSP_CMD_ERASE, 1'b1, 8'hab, 14'h2ac5);
    xfer(1'b1, 8'h20, 32'h11);
    xfer(1'b1, 8'h24, 32'h22);
    @(posedge mclk_i);
    chk("wdata", 64'h40c3090d04002211, flash_wdata_o);
    xfer(1'b1, 8'h00, 32'h84);
    wait_op(FSP_CMD_WRITE, 1'b1, 8'hab, 14'h2ac5);
    xfer(1'b1, 8'h00, 32'hb3);
    wait_op(FSP_CMD_READ, 1'b1, 8'hab, 14'h2ac5);
    rchk("rd lo", 8'h20, 32'h3c);
    rchk("rd hi", 8'h24, 32'h5a);
  endtask : t_ops
  task t_disable;
    xfer(1'b1, 8'h00, 32'h14);
    repeat (6) @(posedge mclk_i);
    chk("wen", 0, write_enabled_o);
    chk("ops", 4, n_ops);
    xfer(1'b1, 8'h08, 32'hff);
    @(posedge mclk_i);
    chk("unit lo", 8'hab, flash_erase_unit_o);
  endtask : t_disable
  initial
  begin
    repeat (16) @(posedge mclk_i);
    rst_b_i <= 1'b1;
    @(posedge mclk_i);
    t_reset();
    t_regs();
    t_bclr();
    t_refused();
    t_unlock(48'h00040d09c240, 1'b0, 8'h60);
    t_unlock(48'h00040d09c340, 1'b1, 8'h60);
    t_unlock(48'h01040d09c340, 1'b0, 8'h60);
    t_timeout();
    t_unlock(48'h00040d09c340, 1'b0, 8'he0);
    t_ops();
    t_disable();
    summarize();
  end
endmodule : fsp_top_test
`default_nettype wire
